// ---- include/move_ops_pkg.sv ----
package move_ops_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  // opcode field of byte-oriented file operations, instr[13:8]
  localparam logic [5:0] OPC_INCR_FIELD = 6'h0A;
  localparam logic [5:0] OPC_IOR_FIELD = 6'h04;
  localparam logic [5:0] OPC_COPY_FIELD = 6'h08;
  localparam logic [5:0] OPC_MISC_FIELD = 6'h00;
  // literal operations decode on instr[13:10]
  localparam logic [3:0] OPC_LOADLIT_FIELD = 4'hC;
  localparam logic [3:0] OPC_RETLIT_FIELD = 4'hD;
  localparam logic [13:0] OPC_IRQ_RETURN = 14'h0009;
  localparam int DEST_BIT = 7;
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INCR_STEP = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  // returns occupy the issue slot for this many cycles in total
  localparam int RETURN_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INCR,
    OP_IOR,
    OP_COPY,
    OP_STORE,
    OP_IRQ_RET,
    OP_LOAD_LIT,
    OP_RET_LIT
  } op_e;
endpackage : move_ops_pkg

// ---- hdl/op_decode.sv ----
`timescale 1ns/1ps
module op_decode
  import move_ops_pkg::*;
(
  // instruction word
  input wire logic [move_ops_pkg::INSTR_W-1:0] instr,
  // decoded fields
  output op_e op,
  output logic dest,
  output logic [move_ops_pkg::FADDR_W-1:0] fileAddr,
  output logic [move_ops_pkg::DATA_W-1:0] literal
);
  import move_ops_pkg::*;

  function automatic op_e classify(input logic [INSTR_W-1:0] w);
    op_e r;
    r = OP_NONE;
    if (w[13:8] == OPC_INCR_FIELD) begin
      r = OP_INCR;
    end else if (w[13:8] == OPC_IOR_FIELD) begin
      r = OP_IOR;
    end else if (w[13:8] == OPC_COPY_FIELD) begin
      r = OP_COPY;
    end else if (w == OPC_IRQ_RETURN) begin
      r = OP_IRQ_RET;
    end else if (w[13:8] == OPC_MISC_FIELD && w[DEST_BIT]) begin
      r = OP_STORE;
    end else if (w[13:10] == OPC_LOADLIT_FIELD) begin
      r = OP_LOAD_LIT;
    end else if (w[13:10] == OPC_RETLIT_FIELD) begin
      r = OP_RET_LIT;
    end
    return r;
  endfunction : classify

  always_comb begin
    op = classify(instr);
    dest = instr[DEST_BIT];
    fileAddr = instr[FADDR_W-1:0];
    // don't-care bits of literal forms are ignored
    literal = instr[DATA_W-1:0];
  end
endmodule : op_decode

// ---- hdl/move_or_return_ops.sv ----
`timescale 1ns/1ps
module move_or_return_ops
  import move_ops_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction issue
  input wire logic instrValid,
  input wire logic [move_ops_pkg::INSTR_W-1:0] instr,
  output logic instrReady,
  output logic instrUnknown,
  // file register read, combinational on instr address
  output logic [move_ops_pkg::FADDR_W-1:0] fileRdAddr,
  input wire logic [move_ops_pkg::DATA_W-1:0] fileRdData,
  // file register write
  output logic fileWrEn,
  output logic [move_ops_pkg::FADDR_W-1:0] fileWrAddr,
  output logic [move_ops_pkg::DATA_W-1:0] fileWrData,
  // stack and program counter
  input wire logic [move_ops_pkg::PC_W-1:0] stackTop,
  output logic stackPop,
  output logic pcLoad,
  output logic [move_ops_pkg::PC_W-1:0] pcValue,
  // core state
  input wire logic globalIrqEnableClear,
  output logic globalIrqEnable,
  output logic [move_ops_pkg::DATA_W-1:0] accum,
  output logic zeroFlag
);
  import move_ops_pkg::*;

  typedef enum logic {ST_ISSUE, ST_FLUSH} phase_e;

  typedef struct packed {
    phase_e phase;
    logic ready;
    logic unknown;
    logic wrEn;
    logic [FADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic pop;
    logic pcLd;
    logic [PC_W-1:0] pc;
    logic irqEn;
    logic [DATA_W-1:0] acc;
    logic zero;
  } state_s;

  state_s cur;
  state_s next_cur;

  op_e op;
  logic dest;
  logic [FADDR_W-1:0] decAddr;
  logic [DATA_W-1:0] literal;
  logic take;
  logic [DATA_W-1:0] result;

  op_decode u_decode (
    .instr(instr),
    .op(op),
    .dest(dest),
    .fileAddr(decAddr),
    .literal(literal)
  );

  assign take = instrValid && cur.ready;

  always_comb begin
    result = fileRdData;
    case (op)
      OP_INCR: result = fileRdData + INCR_STEP;
      OP_IOR: result = cur.acc | fileRdData;
      OP_COPY: result = fileRdData;
      default: result = fileRdData;
    endcase
  end

  always_comb begin
    next_cur = cur;
    next_cur.wrEn = 1'b0;
    next_cur.pop = 1'b0;
    next_cur.pcLd = 1'b0;
    next_cur.unknown = 1'b0;
    // interrupt logic outside may clear; the set below wins
    if (globalIrqEnableClear) begin
      next_cur.irqEn = 1'b0;
    end
    case (cur.phase)
      ST_ISSUE: begin
        if (take) begin
          case (op)
            OP_INCR, OP_IOR, OP_COPY: begin
              next_cur.zero = (result == '0);
              if (dest == DEST_FILE) begin
                // copy-back rewrites the same value; harmless, keeps one path
                next_cur.wrEn = 1'b1;
                next_cur.wrAddr = decAddr;
                next_cur.wrData = result;
              end else begin
                next_cur.acc = result;
              end
            end
            OP_STORE: begin
              next_cur.wrEn = 1'b1;
              next_cur.wrAddr = decAddr;
              next_cur.wrData = cur.acc;
            end
            OP_LOAD_LIT: begin
              next_cur.acc = literal;
            end
            OP_RET_LIT, OP_IRQ_RET: begin
              if (op == OP_RET_LIT) begin
                next_cur.acc = literal;
              end else begin
                next_cur.irqEn = 1'b1;
              end
              next_cur.pop = 1'b1;
              next_cur.pcLd = 1'b1;
              next_cur.pc = stackTop;
              next_cur.ready = 1'b0;
              next_cur.phase = ST_FLUSH;
            end
            default: begin
              next_cur.unknown = 1'b1;
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // second cycle of a return: fetch restarts at the new PC
        next_cur.ready = 1'b1;
        next_cur.phase = ST_ISSUE;
      end
      default: begin
        next_cur.phase = ST_ISSUE;
        next_cur.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur.phase <= ST_ISSUE;
      cur.ready <= 1'b1;
      cur.unknown <= 1'b0;
      cur.wrEn <= 1'b0;
      cur.wrAddr <= '0;
      cur.wrData <= '0;
      cur.pop <= 1'b0;
      cur.pcLd <= 1'b0;
      cur.pc <= PC_RESET;
      cur.irqEn <= 1'b0;
      cur.acc <= ACCUM_RESET;
      cur.zero <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // the read port is combinational on the instruction, not the registered copy
  always_comb begin
    fileRdAddr = decAddr;
  end

  assign instrReady = cur.ready;
  assign instrUnknown = cur.unknown;
  assign fileWrEn = cur.wrEn;
  assign fileWrAddr = cur.wrAddr;
  assign fileWrData = cur.wrData;
  assign stackPop = cur.pop;
  assign pcLoad = cur.pcLd;
  assign pcValue = cur.pc;
  assign globalIrqEnable = cur.irqEn;
  assign accum = cur.acc;
  assign zeroFlag = cur.zero;

  a_incr_write: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_INCR && dest |=> fileWrEn
      && fileWrData == DATA_W'($past(fileRdData) + INCR_STEP)
      && zeroFlag == (fileWrData == '0))
    else $error("increment result or zero flag wrong");

  a_dest_accum: assert property (@(posedge clk) disable iff (!reset_n)
    take && !dest && (op == OP_INCR || op == OP_IOR || op == OP_COPY)
      |=> !fileWrEn && accum == $past(result))
    else $error("destination zero did not go to accumulator");

  a_or_result: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_IOR && !dest
      |=> accum == ($past(accum) | $past(fileRdData)) && zeroFlag == (accum == '0))
    else $error("or result wrong");

  a_copy_test: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_COPY && dest |=> fileWrData == $past(fileRdData)
      && $stable(accum) && zeroFlag == ($past(fileRdData) == '0))
    else $error("copy back altered value or zero flag");

  a_irq_return: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_IRQ_RET |=> pcLoad && stackPop && globalIrqEnable
      && pcValue == $past(stackTop) && $stable(zeroFlag) && $stable(accum))
    else $error("interrupt return wrong");

  a_load_literal: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_LOAD_LIT |=> accum == $past(literal) && $stable(zeroFlag)
      && instrReady && !pcLoad)
    else $error("literal load wrong");

  a_literal_return: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_RET_LIT |=> accum == $past(literal) && pcLoad
      && $stable(zeroFlag) && !instrReady ##1 instrReady && !pcLoad)
    else $error("literal return not two cycles");

  a_store_accum: assert property (@(posedge clk) disable iff (!reset_n)
    take && op == OP_STORE |=> fileWrEn && fileWrData == $past(accum)
      && fileWrAddr == $past(instr[FADDR_W-1:0]) && $stable(zeroFlag))
    else $error("store accumulator wrong");

  a_pop_pairs_load: assert property (@(posedge clk) disable iff (!reset_n)
    stackPop |-> pcLoad ##1 !stackPop)
    else $error("pop without pc load");
endmodule : move_or_return_ops

// ---- test/move_or_return_ops_tb.sv ----
`timescale 1ns/1ps
module move_or_return_ops_tb;
  import move_ops_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid = 1'b0;
  logic [INSTR_W-1:0] instr = '0;
  logic [DATA_W-1:0] fileRdData = '0;
  logic [PC_W-1:0] stackTop = '0;
  logic globalIrqEnableClear = 1'b0;
  logic instrReady, instrUnknown, fileWrEn, stackPop, pcLoad, globalIrqEnable, zeroFlag;
  logic [FADDR_W-1:0] fileRdAddr, fileWrAddr;
  logic [DATA_W-1:0] fileWrData, accum;
  logic [PC_W-1:0] pcValue;
  int fail_count = 0;
  int compares = 0;

  always #2 clk = ~clk;

  move_or_return_ops dut (
    .clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instr(instr),
    .instrReady(instrReady), .instrUnknown(instrUnknown), .fileRdAddr(fileRdAddr),
    .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
    .fileWrData(fileWrData), .stackTop(stackTop), .stackPop(stackPop), .pcLoad(pcLoad),
    .pcValue(pcValue), .globalIrqEnableClear(globalIrqEnableClear),
    .globalIrqEnable(globalIrqEnable), .accum(accum), .zeroFlag(zeroFlag)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // offered at a falling edge; returns at the falling edge after the taking edge
  task automatic issue(input logic [13:0] word, input logic [7:0] rd);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if (instrReady !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED instrReady expected 1 seen %b", instrReady);
      tally_and_finish();
    end
    instrValid = 1'b1;
    instr = word;
    fileRdData = rd;
    #1 chk("fileRdAddr", {9'h0, word[6:0]}, {9'h0, fileRdAddr});
    @(posedge clk);
    @(negedge clk);
  endtask : issue

  // caller must idle or reissue at once, or the held word is taken again
  task automatic idle();
    instrValid = 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic wr(input logic en, input logic [6:0] a, input logic [7:0] d);
    chk("fileWrEn", en, fileWrEn);
    if (en) chk("fileWrAddr", a, fileWrAddr);
    if (en) chk("fileWrData", d, fileWrData);
  endtask : wr

  task automatic t_incr();
    issue(14'h0AFF, 8'hFF);
    wr(1, 7'h7F, 8'h00);
    chk("zeroFlag", 1, zeroFlag);
    issue(14'h0A05, 8'h41);
    chk("accum", 8'h42, accum);
    chk("zeroFlag", 0, zeroFlag);
    wr(0, 0, 0);
    idle();
    $display("increment test done");
  endtask : t_incr

  task automatic t_lit_or();
    issue(14'h0805, 8'h00);
    chk("accum", 8'h00, accum);
    chk("zeroFlag", 1, zeroFlag);
    issue(14'h30FF, 8'h00);
    chk("accum", 8'hFF, accum);
    chk("zeroFlag", 1, zeroFlag);
    issue(14'h3300, 8'h00);
    chk("accum", 8'h00, accum);
    issue(14'h300F, 8'h00);
    issue(14'h0410, 8'hF0);
    chk("accum", 8'hFF, accum);
    chk("zeroFlag", 0, zeroFlag);
    issue(14'h0490, 8'h00);
    wr(1, 7'h10, 8'hFF);
    issue(14'h3000, 8'h00);
    issue(14'h0411, 8'h00);
    chk("zeroFlag", 1, zeroFlag);
    chk("instrReady", 1, instrReady);
    idle();
    $display("literal and or test done");
  endtask : t_lit_or

  task automatic t_copy_store();
    issue(14'h305A, 8'h00);
    issue(14'h08A3, 8'h00);
    wr(1, 7'h23, 8'h00);
    chk("zeroFlag", 1, zeroFlag);
    chk("accum", 8'h5A, accum);
    issue(14'h0080, 8'h00);
    wr(1, 7'h00, 8'h5A);
    chk("zeroFlag", 1, zeroFlag);
    issue(14'h00FF, 8'h00);
    wr(1, 7'h7F, 8'h5A);
    issue(14'h0100, 8'h00);
    chk("instrUnknown", 1, instrUnknown);
    wr(0, 0, 0);
    idle();
    $display("copy and store test done");
  endtask : t_copy_store

  task automatic t_returns();
    stackTop = 13'h1ABC;
    issue(14'h34A5, 8'h00);
    chk("accum", 8'hA5, accum);
    chk("pcLoad", 1, pcLoad);
    chk("stackPop", 1, stackPop);
    chk("pcValue", 13'h1ABC, pcValue);
    chk("zeroFlag", 1, zeroFlag);
    chk("instrReady", 0, instrReady);
    // offered during the flush slot, must be ignored
    instr = 14'h3011;
    @(negedge clk);
    chk("pcLoad", 0, pcLoad);
    chk("instrReady", 1, instrReady);
    idle();
    chk("accum", 8'hA5, accum);
    globalIrqEnableClear = 1'b1;
    @(negedge clk);
    globalIrqEnableClear = 1'b0;
    chk("globalIrqEnable", 0, globalIrqEnable);
    stackTop = 13'h0123;
    issue(14'h0009, 8'h00);
    chk("globalIrqEnable", 1, globalIrqEnable);
    chk("stackPop", 1, stackPop);
    chk("pcValue", 13'h0123, pcValue);
    chk("pcLoad", 1, pcLoad);
    chk("zeroFlag", 1, zeroFlag);
    chk("accum", 8'hA5, accum);
    chk("instrReady", 0, instrReady);
    idle();
    chk("instrReady", 1, instrReady);
    // enable is set now, so the clear must really drop it
    globalIrqEnableClear = 1'b1;
    @(negedge clk);
    chk("globalIrqEnable", 0, globalIrqEnable);
    // clear still high while the return is taken: the set wins
    issue(14'h0009, 8'h00);
    globalIrqEnableClear = 1'b0;
    chk("globalIrqEnable", 1, globalIrqEnable);
    chk("pcLoad", 1, pcLoad);
    idle();
    $display("return test done");
  endtask : t_returns

  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    chk("instrReady", 1, instrReady);
    chk("accum", 8'h00, accum);
    chk("pcValue", 13'h0000, pcValue);
    t_incr();
    t_lit_or();
    t_copy_store();
    t_returns();
    tally_and_finish();
  end
endmodule : move_or_return_ops_tb
